// file: inc/rstc_pkg.sv
// constants, register map and state type for the reset source and cause block
`default_nettype none
package rstc_pkg;
    // register byte offsets
    localparam logic [7:0]  OFS_CAUSE     = 8'h00;
    localparam logic [7:0]  OFS_WDT_KEY   = 8'h04;
    localparam logic [7:0]  OFS_CORE_CTRL = 8'h08;
    localparam logic [7:0]  OFS_WDT_MATCH = 8'h0c;
    localparam logic [7:0]  OFS_WDT_SVC   = 8'h10;
    localparam logic [7:0]  OFS_WDT_COUNT = 8'h14;
    localparam logic [7:0]  OFS_INT_STAT  = 8'h18;
    localparam logic [7:0]  OFS_INT_MASK  = 8'h1c;
    localparam logic [7:0]  OFS_STATUS    = 8'h20;
    // field positions
    localparam int          CAUSE_WDT_BIT   = 0;
    localparam int          CAUSE_SOFT_BIT  = 1;
    localparam int          CAUSE_PROT_BIT  = 2;
    localparam int          RST_REQ_BIT     = 2;
    localparam int          INT_WARN_BIT    = 0;
    localparam int          INT_BOOT_BIT    = 1;
    // keys
    localparam logic [31:0] WDOG_OFF_KEY    = 32'haced8865;
    localparam logic [15:0] CORE_CTRL_KEY   = 16'ha05f;
    localparam logic [3:0]  STRB_ALL        = 4'hf;
    // reset values
    localparam logic [15:0] WDT_MATCH_RST   = 16'h1000;
    localparam logic        WDT_EN_RST      = 1'h1;
    localparam logic [2:0]  CAUSE_RST       = 3'h0;
    localparam logic [1:0]  INT_RST         = 2'h0;
    localparam logic [1:0]  SYNC_SV_RST     = 2'h0;
    localparam logic [1:0]  SYNC_BO_RST     = 2'h3;
    localparam logic [1:0]  SYNC_XR_RST     = 2'h0;
    // timing
    localparam int          CLK_PERIOD_NS   = 8;
    localparam int          RESET_HOLD_NS   = 1000;
    localparam int          RESET_HOLD_CYC  =
        (RESET_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [7:0]  HOLD_LAST       = 8'(RESET_HOLD_CYC - 1);
    // bus answers
    localparam logic [1:0]  RESP_OKAY       = 2'h0;
    localparam logic [1:0]  RESP_SLVERR     = 2'h2;

    typedef enum logic [1:0] {ST_COLD, ST_HOLD, ST_RUN} rstc_state_t;
endpackage
`default_nettype wire

// file: inc/rstc_wdt_if.sv
// link between the reset controller and its watchdog counter
`timescale 1ns/100ps
`default_nettype none
interface rstc_wdt_if;
    logic        enable;
    logic        run;
    logic        service;
    logic [15:0] match_val;
    logic [15:0] count;
    logic        expire;
    logic        warn;

    modport ctl (output enable, run, service, match_val, input count, expire, warn);
    modport wdt (input enable, run, service, match_val, output count, expire, warn);
endinterface
`default_nettype wire

// file: logic/rstc_wdt.sv
// watchdog counter: expires when not serviced before the match count
`timescale 1ns/100ps
`default_nettype none
module rstc_wdt
(
    // clock and reset
    input  wire logic aclk,
    input  wire logic aresetn,
    // controller side
    rstc_wdt_if.wdt   wif
);
    typedef struct packed {
        logic [15:0] count;
        logic        expire;
        logic        warn;
    } rstc_wdt_regs_t;

    rstc_wdt_regs_t s_q;
    rstc_wdt_regs_t s_d;
    logic [15:0]    nxt;

    always_comb
    begin
        s_d        = s_q;
        s_d.expire = 1'h0;
        s_d.warn   = 1'h0;
        nxt        = s_q.count + 16'h1;
        if (!aresetn || !wif.run || !wif.enable || wif.service)
        begin
            s_d.count = 16'h0;
        end
        else if (s_q.count >= wif.match_val)
        begin
            s_d.expire = 1'h1;
            s_d.count  = 16'h0;
        end
        else
        begin
            s_d.count = nxt;
            // early warning halfway, so firmware can still service
            s_d.warn  = (nxt == {1'h0, wif.match_val[15:1]});
        end
    end

    always_ff @(posedge aclk)
    begin
        s_q <= s_d;
    end

    assign wif.count  = s_q.count;
    assign wif.expire = s_q.expire;
    assign wif.warn   = s_q.warn;
endmodule // rstc_wdt
`default_nettype wire

// file: logic/rstc_top.sv
// reset source combiner with sticky cause flags and an axi4-lite register port
// Contract
// - watchdog expiry issues system reset; watchdog enabled after every reset
// - only key 0xACED8865 in the disable key register turns the watchdog off
// - watchdog reset sets watchdog cause flag, kept through other warm resets
// - writing key A05F with the request bit set triggers software reset
// - software reset sets software cause flag, kept through other warm resets
// - a protection violation resets the device
// - protection reset sets protection cause flag, kept through warm resets
// - external reset pin active low; low resets, high has no effect
// - device held in reset while pin low, boots normally after release
// - power-on, brownout, external resets set no flag and clear all flags
// - power-on reset holds device in reset until supply valid
// - brownout reset whenever supply monitor reports low, in every mode
`timescale 1ns/100ps
`default_nettype none
module rstc_top
(
    // clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // axi4-lite write address
    input  wire logic [7:0]  awaddr,
    input  wire logic        awvalid,
    output wire logic        awready,
    // axi4-lite write data
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output wire logic        wready,
    // axi4-lite write response
    output wire logic [1:0]  bresp,
    output wire logic        bvalid,
    input  wire logic        bready,
    // axi4-lite read address
    input  wire logic [7:0]  araddr,
    input  wire logic        arvalid,
    output wire logic        arready,
    // axi4-lite read data
    output wire logic [31:0] rdata,
    output wire logic [1:0]  rresp,
    output wire logic        rvalid,
    input  wire logic        rready,
    // reset sources
    input  wire logic        supply_valid,
    input  wire logic        brownout_reset,
    input  wire logic        external_reset_n,
    input  wire logic        protection_violation_reset,
    // results
    output wire logic        sys_reset_n,
    output wire logic        irq
);
    typedef struct packed {
        logic [1:0]           sv_sync;
        logic [1:0]           bo_sync;
        logic [1:0]           xr_sync;
        rstc_pkg::rstc_state_t state;
        logic [7:0]           hold_cnt;
        logic                 sys_rst_n;
        logic [2:0]           cause;
        logic                 wdt_en;
        logic [15:0]          wdt_match;
        logic                 wdt_svc;
        logic [1:0]           int_stat;
        logic [1:0]           int_mask;
        logic                 irq;
        logic                 aw_have;
        logic                 w_have;
        logic [7:0]           aw_addr;
        logic [31:0]          w_data;
        logic [3:0]           w_strb;
        logic                 awready;
        logic                 wready;
        logic                 bvalid;
        logic [1:0]           bresp;
        logic                 arready;
        logic                 rvalid;
        logic [31:0]          rdata;
        logic [1:0]           rresp;
    } rstc_regs_t;

    rstc_regs_t  s_q;
    rstc_regs_t  s_d;
    rstc_wdt_if  wif ();

    logic        cold;
    logic        wr_fire;
    logic        wr_full;
    logic        soft_hit;
    logic        prot_hit;
    logic        warm;
    logic [2:0]  cause_set;
    logic [31:0] match_mrg;
    logic [31:0] mask_mrg;

    // byte-lane merge for partially strobed writes
    function automatic logic [31:0] merge_bytes
    (
        input logic [31:0] old_v,
        input logic [31:0] new_v,
        input logic [3:0]  strb
    );
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++)
        begin
            if (strb[i])
            begin
                r[8*i +: 8] = new_v[8*i +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic is_wr
    (
        input logic [7:0] a,
        input logic [7:0] ofs
    );
        return (a == ofs);
    endfunction

    rstc_wdt rstc_wdt_i
    (
        .aclk    (aclk),
        .aresetn (aresetn),
        .wif     (wif)
    );

    assign wif.enable    = s_q.wdt_en;
    assign wif.run       = (s_q.state == rstc_pkg::ST_RUN);
    assign wif.service   = s_q.wdt_svc;
    assign wif.match_val = s_q.wdt_match;

    always_comb
    begin
        s_d = s_q;

        // two-stage synchronisers on the asynchronous sources
        s_d.sv_sync = {s_q.sv_sync[0], supply_valid};
        s_d.bo_sync = {s_q.bo_sync[0], brownout_reset};
        s_d.xr_sync = {s_q.xr_sync[0], external_reset_n};

        cold = !s_q.sv_sync[1] || s_q.bo_sync[1] || !s_q.xr_sync[1];

        // write channel capture, either order
        if (awvalid && s_q.awready)
        begin
            s_d.aw_have = 1'h1;
            s_d.aw_addr = awaddr;
            s_d.awready = 1'h0;
        end
        if (wvalid && s_q.wready)
        begin
            s_d.w_have = 1'h1;
            s_d.w_data = wdata;
            s_d.w_strb = wstrb;
            s_d.wready = 1'h0;
        end

        wr_fire   = s_q.aw_have && s_q.w_have && !s_q.bvalid;
        wr_full   = (s_q.w_strb == rstc_pkg::STRB_ALL);
        match_mrg = merge_bytes({16'h0, s_q.wdt_match}, s_q.w_data, s_q.w_strb);
        mask_mrg  = merge_bytes({30'h0, s_q.int_mask}, s_q.w_data, s_q.w_strb);
        s_d.wdt_svc = 1'h0;
        soft_hit  = 1'h0;

        if (wr_fire)
        begin
            s_d.aw_have = 1'h0;
            s_d.w_have  = 1'h0;
            s_d.bvalid  = 1'h1;
            s_d.bresp   = rstc_pkg::RESP_OKAY;
            case (s_q.aw_addr)
                rstc_pkg::OFS_CAUSE:
                begin
                    if (s_q.w_strb[0])
                    begin
                        s_d.cause = s_q.cause & ~s_q.w_data[2:0];
                    end
                end
                rstc_pkg::OFS_WDT_KEY:
                begin
                    if (wr_full)
                    begin
                        s_d.wdt_en = (s_q.w_data != rstc_pkg::WDOG_OFF_KEY);
                    end
                end
                rstc_pkg::OFS_CORE_CTRL:
                begin
                    soft_hit = wr_full
                        && (s_q.w_data[31:16] == rstc_pkg::CORE_CTRL_KEY)
                        && s_q.w_data[rstc_pkg::RST_REQ_BIT];
                end
                rstc_pkg::OFS_WDT_MATCH:
                begin
                    s_d.wdt_match = match_mrg[15:0];
                end
                rstc_pkg::OFS_WDT_SVC:
                begin
                    s_d.wdt_svc = 1'h1;
                end
                rstc_pkg::OFS_INT_STAT:
                begin
                    if (s_q.w_strb[0])
                    begin
                        s_d.int_stat = s_q.int_stat & ~s_q.w_data[1:0];
                    end
                end
                rstc_pkg::OFS_INT_MASK:
                begin
                    s_d.int_mask = mask_mrg[1:0];
                end
                rstc_pkg::OFS_WDT_COUNT, rstc_pkg::OFS_STATUS:
                begin
                    s_d.bresp = rstc_pkg::RESP_OKAY;
                end
                default:
                begin
                    s_d.bresp = rstc_pkg::RESP_SLVERR;
                end
            endcase
        end
        if (s_q.bvalid && bready)
        begin
            s_d.bvalid  = 1'h0;
            s_d.awready = 1'h1;
            s_d.wready  = 1'h1;
        end

        // read channel, one outstanding
        if (arvalid && s_q.arready)
        begin
            s_d.arready = 1'h0;
            s_d.rvalid  = 1'h1;
            s_d.rresp   = rstc_pkg::RESP_OKAY;
            case (araddr)
                rstc_pkg::OFS_CAUSE:     s_d.rdata = {29'h0, s_q.cause};
                rstc_pkg::OFS_WDT_KEY:   s_d.rdata = 32'h0;
                rstc_pkg::OFS_CORE_CTRL: s_d.rdata = 32'h0;
                rstc_pkg::OFS_WDT_MATCH: s_d.rdata = {16'h0, s_q.wdt_match};
                rstc_pkg::OFS_WDT_SVC:   s_d.rdata = 32'h0;
                rstc_pkg::OFS_WDT_COUNT: s_d.rdata = {16'h0, wif.count};
                rstc_pkg::OFS_INT_STAT:  s_d.rdata = {30'h0, s_q.int_stat};
                rstc_pkg::OFS_INT_MASK:  s_d.rdata = {30'h0, s_q.int_mask};
                rstc_pkg::OFS_STATUS:    s_d.rdata = {29'h0, s_q.state, s_q.wdt_en};
                default:
                begin
                    s_d.rdata = 32'h0;
                    s_d.rresp = rstc_pkg::RESP_SLVERR;
                end
            endcase
        end
        if (s_q.rvalid && rready)
        begin
            s_d.rvalid  = 1'h0;
            s_d.arready = 1'h1;
        end

        prot_hit = protection_violation_reset;
        cause_set = 3'h0;
        cause_set[rstc_pkg::CAUSE_WDT_BIT]  = wif.expire;
        cause_set[rstc_pkg::CAUSE_SOFT_BIT] = soft_hit;
        cause_set[rstc_pkg::CAUSE_PROT_BIT] = prot_hit;
        warm = (s_q.state == rstc_pkg::ST_RUN) && (|cause_set);

        if (s_q.wdt_en && wif.warn)
        begin
            s_d.int_stat[rstc_pkg::INT_WARN_BIT] = 1'h1;
        end

        // reset sequencer
        case (s_q.state)
            rstc_pkg::ST_COLD:
            begin
                s_d.sys_rst_n = 1'h0;
                s_d.hold_cnt  = 8'h0;
                s_d.state     = rstc_pkg::ST_HOLD;
            end
            rstc_pkg::ST_HOLD:
            begin
                s_d.sys_rst_n = 1'h0;
                s_d.hold_cnt  = s_q.hold_cnt + 8'h1;
                if (s_q.hold_cnt == rstc_pkg::HOLD_LAST)
                begin
                    s_d.state     = rstc_pkg::ST_RUN;
                    s_d.sys_rst_n = 1'h1;
                    s_d.int_stat[rstc_pkg::INT_BOOT_BIT] = 1'h1;
                end
            end
            rstc_pkg::ST_RUN:
            begin
                if (warm)
                begin
                    // warm reset, cause kept, flags survive
                    s_d.state     = rstc_pkg::ST_HOLD;
                    s_d.sys_rst_n = 1'h0;
                    s_d.hold_cnt  = 8'h0;
                    s_d.cause     = s_d.cause | cause_set;
                end
            end
            default:
            begin
                s_d.state     = rstc_pkg::ST_COLD;
                s_d.sys_rst_n = 1'h0;
            end
        endcase

        // watchdog back to defaults during any reset
        if (s_d.state != rstc_pkg::ST_RUN)
        begin
            s_d.wdt_en    = rstc_pkg::WDT_EN_RST;
            s_d.wdt_match = rstc_pkg::WDT_MATCH_RST;
        end

        if (cold)
        begin
            s_d.state     = rstc_pkg::ST_COLD;
            s_d.sys_rst_n = 1'h0;
            s_d.cause     = rstc_pkg::CAUSE_RST;
        end

        s_d.irq = |(s_d.int_stat & s_d.int_mask);

        if (!aresetn)
        begin
            s_d.sv_sync   = rstc_pkg::SYNC_SV_RST;
            s_d.bo_sync   = rstc_pkg::SYNC_BO_RST;
            s_d.xr_sync   = rstc_pkg::SYNC_XR_RST;
            s_d.state     = rstc_pkg::ST_COLD;
            s_d.hold_cnt  = 8'h0;
            s_d.sys_rst_n = 1'h0;
            s_d.cause     = rstc_pkg::CAUSE_RST;
            s_d.wdt_en    = rstc_pkg::WDT_EN_RST;
            s_d.wdt_match = rstc_pkg::WDT_MATCH_RST;
            s_d.wdt_svc   = 1'h0;
            s_d.int_stat  = rstc_pkg::INT_RST;
            s_d.int_mask  = rstc_pkg::INT_RST;
            s_d.irq       = 1'h0;
            s_d.aw_have   = 1'h0;
            s_d.w_have    = 1'h0;
            s_d.aw_addr   = 8'h0;
            s_d.w_data    = 32'h0;
            s_d.w_strb    = 4'h0;
            s_d.awready   = 1'h1;
            s_d.wready    = 1'h1;
            s_d.bvalid    = 1'h0;
            s_d.bresp     = rstc_pkg::RESP_OKAY;
            s_d.arready   = 1'h1;
            s_d.rvalid    = 1'h0;
            s_d.rdata     = 32'h0;
            s_d.rresp     = rstc_pkg::RESP_OKAY;
        end
    end

    always_ff @(posedge aclk)
    begin
        s_q <= s_d;
    end

    assign awready     = s_q.awready;
    assign wready      = s_q.wready;
    assign bvalid      = s_q.bvalid;
    assign bresp       = s_q.bresp;
    assign arready     = s_q.arready;
    assign rvalid      = s_q.rvalid;
    assign rdata       = s_q.rdata;
    assign rresp       = s_q.rresp;
    assign sys_reset_n = s_q.sys_rst_n;
    assign irq         = s_q.irq;
endmodule // rstc_top
`default_nettype wire

// file: verif/rstc_chk_asserts.sv
// port-level assertions for the reset combiner
`timescale 1ns/100ps
`default_nettype none
module rstc_chk
(
    // clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    // bus handshakes
    input wire logic        awvalid,
    input wire logic        awready,
    input wire logic        wvalid,
    input wire logic        wready,
    input wire logic        bvalid,
    input wire logic        bready,
    input wire logic        arvalid,
    input wire logic        arready,
    input wire logic        rvalid,
    input wire logic        rready,
    input wire logic [1:0]  bresp,
    input wire logic [1:0]  rresp,
    input wire logic [31:0] rdata,
    // reset sources and result
    input wire logic        supply_valid,
    input wire logic        brownout_reset,
    input wire logic        external_reset_n,
    input wire logic        protection_violation_reset,
    input wire logic        sys_reset_n
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    logic [7:0] low_cnt_q;
    // saturates so a long pin hold cannot wrap
    always_ff @(posedge aclk)
        if (!aresetn || sys_reset_n)
            low_cnt_q <= 8'h00;
        else if (low_cnt_q != 8'hff)
            low_cnt_q <= low_cnt_q + 8'h01;

    pin_reset_a: assert property ((!external_reset_n) [*3] |=> !sys_reset_n)
        else $error("pin low did not reset");
    supply_low_a: assert property ((!supply_valid) [*3] |=> !sys_reset_n)
        else $error("invalid supply did not reset");
    brownout_hit_a: assert property (brownout_reset [*3] |=> !sys_reset_n)
        else $error("brownout did not reset");
    prot_reset_a: assert property (sys_reset_n && protection_violation_reset
        |-> ##[1:2] !sys_reset_n) else $error("violation did not reset");
    hold_time_a: assert property ($rose(sys_reset_n) |-> low_cnt_q >= 8'h7d)
        else $error("system reset released too early");
    wr_answer_a: assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid)
        else $error("write answer late");
    wr_stands_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write answer dropped");
    rd_answer_a: assert property (arvalid && arready |=> rvalid && !arready)
        else $error("read answer late");
    rd_stands_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata)
        && $stable(rresp)) else $error("read answer dropped");
endmodule // rstc_chk
`default_nettype wire

// file: verif/rstc_src_model.sv
// pin, supply monitors and fault source facing the reset combiner
`timescale 1ns/100ps
`default_nettype none
module rstc_src_model
(
    // clock
    input  wire logic aclk,
    // reset sources
    output var logic  supply_valid,
    output var logic  brownout_reset,
    output wire logic external_reset_n,
    output var logic  protection_violation_reset
);
    logic pull_low;
    // pull-up: a released pin reads high
    assign external_reset_n = !pull_low;
    // supply starts invalid, as at power-up
    initial
    begin
        pull_low = 1'b0;
        supply_valid = 1'b0;
        brownout_reset = 1'b0;
        protection_violation_reset = 1'b0;
    end
    // cold source held until the bench lets go
    task automatic cold(input int k, input logic on);
        case (k)
            0: pull_low <= on;
            1: brownout_reset <= on;
            default: supply_valid <= !on;
        endcase
    endtask
    task automatic fault();
        protection_violation_reset <= 1'b1;
        @(posedge aclk);
        protection_violation_reset <= 1'b0;
    endtask
endmodule // rstc_src_model
`default_nettype wire

// file: verif/tb_reset_source_and_cause_logic.sv
// self-checking bench for the reset source and cause block
`timescale 1ns/100ps
`default_nettype none
module tb_reset_source_and_cause_logic;
    logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rd;
    logic [3:0]  wstrb;
    logic [1:0]  rs;
    wire  [31:0] rdata;
    wire  [1:0]  bresp, rresp;
    wire         awready, wready, bvalid, arready, rvalid, sys_reset_n, irq;
    wire         sv, bo, xr_n, pv;
    int          bad_count, cmp_count, cyc;

    rstc_top rstc_top_i
    (
        .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready), .supply_valid(sv), .brownout_reset(bo),
        .external_reset_n(xr_n), .protection_violation_reset(pv),
        .sys_reset_n(sys_reset_n), .irq(irq)
    );
    rstc_src_model rstc_src_model_i
    (
        .aclk(aclk), .supply_valid(sv), .brownout_reset(bo), .external_reset_n(xr_n),
        .protection_violation_reset(pv)
    );

    initial
    begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end

    // hang guard, far above the few thousand cycles the run needs
    always @(posedge aclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            bad_count++;
            stop_test();
        end
    end

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        awaddr <= a;
        wdata <= d;
        wstrb <= rstc_pkg::STRB_ALL;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (awready)
                awvalid <= 1'b0;
            if (wready)
                wvalid <= 1'b0;
        end while (!bvalid);
        rs = bresp;
        bready <= 1'b0;
        @(posedge aclk);
    endtask

    task automatic rd_reg(input logic [7:0] a);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (arready)
                arvalid <= 1'b0;
        end while (!rvalid);
        rd = rdata;
        rs = rresp;
        rready <= 1'b0;
        @(posedge aclk);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        rd_reg(a);
        chk("rdata", exp, rd);
        chk("rresp", {30'h0, rstc_pkg::RESP_OKAY}, {30'h0, rs});
    endtask

    task automatic expect_rst(input int lim);
        int n;
        n = 0;
        while (sys_reset_n !== 1'b0 && n < lim)
        begin
            @(posedge aclk);
            n++;
        end
        chk("sys_reset_n", 32'h0, {31'h0, sys_reset_n});
    endtask

    task automatic keep_run(input int n);
        repeat (n) @(posedge aclk);
        chk("sys_reset_n", 32'h1, {31'h0, sys_reset_n});
    endtask

    task automatic wait_run();
        while (sys_reset_n !== 1'b1)
            @(posedge aclk);
    endtask

    initial
    begin
        aresetn = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        {awaddr, araddr, wdata, wstrb} = 52'h0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (10) @(posedge aclk);
        rstc_src_model_i.cold(2, 1'b0);
        wait_run();
        rdc(rstc_pkg::OFS_CAUSE, 32'h0);
        rdc(rstc_pkg::OFS_STATUS, 32'h5);
        $display("test boot done");
        rdc(rstc_pkg::OFS_INT_STAT, 32'h2);
        chk("irq", 32'h0, {31'h0, irq});
        wr(rstc_pkg::OFS_INT_MASK, 32'h2);
        repeat (2) @(posedge aclk);
        chk("irq", 32'h1, {31'h0, irq});
        wr(rstc_pkg::OFS_INT_STAT, 32'h2);
        repeat (2) @(posedge aclk);
        chk("irq", 32'h0, {31'h0, irq});
        wr(8'h40, 32'hffffffff);
        chk("bresp", {30'h0, rstc_pkg::RESP_SLVERR}, {30'h0, rs});
        rd_reg(8'h40);
        chk("rresp", {30'h0, rstc_pkg::RESP_SLVERR}, {30'h0, rs});
        chk("rdata", 32'h0, rd);
        $display("test interrupt and unmapped done");
        wr(rstc_pkg::OFS_WDT_KEY, 32'haced8864);
        rdc(rstc_pkg::OFS_STATUS, 32'h5);
        wr(rstc_pkg::OFS_WDT_KEY, rstc_pkg::WDOG_OFF_KEY);
        rdc(rstc_pkg::OFS_STATUS, 32'h4);
        wr(rstc_pkg::OFS_WDT_MATCH, 32'h10);
        wr(rstc_pkg::OFS_WDT_SVC, 32'h1);
        keep_run(60);
        wr(rstc_pkg::OFS_WDT_KEY, 32'h0);
        expect_rst(60);
        wait_run();
        rdc(rstc_pkg::OFS_CAUSE, 32'h1);
        rdc(rstc_pkg::OFS_WDT_MATCH, 32'h1000);
        // halfway warning before expiry, boot bit set again on warm release
        rdc(rstc_pkg::OFS_INT_STAT, 32'h3);
        $display("test watchdog done");
        wr(rstc_pkg::OFS_CORE_CTRL, 32'ha05e0004);
        keep_run(10);
        wr(rstc_pkg::OFS_CORE_CTRL, 32'ha05f0000);
        keep_run(10);
        wr(rstc_pkg::OFS_CORE_CTRL, 32'ha05f0004);
        expect_rst(10);
        wait_run();
        rdc(rstc_pkg::OFS_CAUSE, 32'h3);
        rstc_src_model_i.fault();
        expect_rst(10);
        wait_run();
        rdc(rstc_pkg::OFS_CAUSE, 32'h7);
        wr(rstc_pkg::OFS_CAUSE, 32'h0);
        rdc(rstc_pkg::OFS_CAUSE, 32'h7);
        wr(rstc_pkg::OFS_CAUSE, 32'h2);
        rdc(rstc_pkg::OFS_CAUSE, 32'h5);
        $display("test warm causes done");
        // pin, brownout, supply in turn, each over a freshly set flag
        for (int k = 0; k < 3; k++)
        begin
            rstc_src_model_i.fault();
            expect_rst(10);
            wait_run();
            rstc_src_model_i.cold(k, 1'b1);
            expect_rst(10);
            repeat (200) @(posedge aclk);
            chk("sys_reset_n", 32'h0, {31'h0, sys_reset_n});
            rstc_src_model_i.cold(k, 1'b0);
            wait_run();
            rdc(rstc_pkg::OFS_CAUSE, 32'h0);
        end
        $display("test cold resets done");
        stop_test();
    end
endmodule // tb_reset_source_and_cause_logic

bind rstc_top rstc_chk rstc_chk_i
(
    .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
    .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .bready(bready),
    .arvalid(arvalid), .arready(arready), .rvalid(rvalid), .rready(rready),
    .bresp(bresp), .rresp(rresp), .rdata(rdata), .supply_valid(supply_valid),
    .brownout_reset(brownout_reset), .external_reset_n(external_reset_n),
    .protection_violation_reset(protection_violation_reset), .sys_reset_n(sys_reset_n)
);
`default_nettype wire
